//--- xlm_pkg.sv
`default_nettype none
package xlm_pkg;

  // Clock and tick timing
  localparam int CLK_KHZ = 20000;
  localparam int TICK_MS = 500;
  localparam int HALF_SEC_CYCLES = TICK_MS * CLK_KHZ;

  // Persistence thresholds in milliseconds and in half-second ticks
  localparam int DECLARE_MS = 2500;
  localparam int CLEAR_MS = 10000;
  localparam logic [4:0] DECLARE_TICKS = 5'(DECLARE_MS / TICK_MS);
  localparam logic [4:0] CLEAR_TICKS = 5'(CLEAR_MS / TICK_MS);

  // Per-second performance limits
  localparam logic [7:0] SES_CRC_LIMIT = 8'h12;
  localparam logic [3:0] UAS_RUN = 4'hA;
  localparam logic [31:0] UAS_RUN_W = 32'h0000000A;
  localparam int CRC_GROUPS = 4;

  // Register offsets
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_CLEAR = 8'h04;
  localparam logic [7:0] REG_FAIL = 8'h08;
  localparam logic [7:0] REG_ES = 8'h0C;
  localparam logic [7:0] REG_SES = 8'h10;
  localparam logic [7:0] REG_UAS = 8'h14;
  localparam logic [7:0] REG_STATE = 8'h18;

  // Control field positions and reset values
  localparam int CTRL_ENABLE_BIT = 0;
  localparam logic [31:0] CTRL_RESET = 32'h00000001;
  localparam int STATE_UNAVAIL_BIT = 0;

  typedef enum logic {
    XLM_AVAILABLE,
    XLM_UNAVAILABLE
  } xlm_avail_e;

  typedef struct packed {
    logic near_signal_absent;
    logic far_signal_absent;
    logic severely_errored_frame;
    logic remote_defect_flag;
    logic near_power_loss;
    logic far_power_loss;
  } xlm_defect_s;

  typedef struct packed {
    logic far_power_loss;
    logic near_power_loss;
    logic far_frame_sync_lost;
    logic near_frame_sync_lost;
    logic far_signal_absent;
    logic near_signal_absent;
  } xlm_fail_s;

  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } xlm_bus_s;

endpackage
`default_nettype wire

//--- xlm_persist.sv
`default_nettype none
module xlm_persist #(
  parameter logic [4:0] SET_TICKS = 5'h05,
  parameter logic [4:0] CLR_TICKS = 5'h14
) (
  input wire logic core_clk_in,
  input wire logic reset_in,
  input wire logic tick_in,
  input wire logic defect_in,
  input wire logic block_in,
  input wire logic force_set_in,
  input wire logic force_clr_in,
  output logic fail_out,
  output logic criteria_out
);
  logic [4:0] cnt_ff;
  logic [4:0] nxt_cnt;
  logic fail_ff;
  logic nxt_fail;
  logic met_ff;
  logic nxt_met;

  always_comb begin
    nxt_cnt = cnt_ff;
    nxt_fail = fail_ff;
    // Criteria stay met while the run goes on past declaration
    nxt_met = defect_in && (met_ff || (!fail_ff && cnt_ff == SET_TICKS));
    if (!fail_ff) begin
      // Any gap in the defect restarts the run
      if (!defect_in) begin
        nxt_cnt = 5'h00;
      end else if (tick_in && cnt_ff != SET_TICKS) begin
        nxt_cnt = cnt_ff + 5'h01;
      end
      if (force_set_in ||
          (defect_in && cnt_ff == SET_TICKS && !block_in)) begin
        nxt_fail = 1'b1;
        nxt_cnt = 5'h00;
      end
    end else begin
      if (defect_in) begin
        nxt_cnt = 5'h00;
      end else if (tick_in && cnt_ff != CLR_TICKS) begin
        nxt_cnt = cnt_ff + 5'h01;
      end
      if (force_clr_in || (!defect_in && cnt_ff == CLR_TICKS)) begin
        nxt_fail = 1'b0;
        nxt_cnt = 5'h00;
      end
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      cnt_ff <= 5'h00;
      fail_ff <= 1'b0;
      met_ff <= 1'b0;
    end else begin
      cnt_ff <= nxt_cnt;
      fail_ff <= nxt_fail;
      met_ff <= nxt_met;
    end
  end

  assign fail_out = fail_ff;
  // Criteria seen even while the declaration is held off
  assign criteria_out = nxt_met;

endmodule // xlm_persist
`default_nettype wire

//--- xlm_line_monitor.sv
`default_nettype none
module xlm_line_monitor #(
  parameter int HALF_SEC_CYCLES = xlm_pkg::HALF_SEC_CYCLES
) (
  input wire logic core_clk_in,
  input wire logic reset_in,
  input wire xlm_pkg::xlm_defect_s defect_in,
  input wire logic [xlm_pkg::CRC_GROUPS-1:0] crc_anomaly_in,
  input wire xlm_pkg::xlm_bus_s bus_in,
  output logic [31:0] rd_data_out,
  output xlm_pkg::xlm_fail_s failure_out,
  output logic unavailable_out,
  output logic sec_tick_out
);
  import xlm_pkg::*;

  function automatic logic [7:0] crc_count(
      input logic [CRC_GROUPS-1:0] v);
    logic [7:0] n;
    n = 8'h00;
    for (int i = 0; i < CRC_GROUPS; i++) begin
      n = n + {7'h00, v[i]};
    end
    return n;
  endfunction

  function automatic logic [7:0] sat_add8(input logic [7:0] a,
                                          input logic [7:0] b);
    logic [8:0] s;
    s = {1'b0, a} + {1'b0, b};
    return s[8] ? 8'hFF : s[7:0];
  endfunction

  // Tick generation
  logic [23:0] div_ff;
  logic [23:0] nxt_div;
  logic phase_ff;
  logic nxt_phase;
  logic half_tick;
  logic sec_tick;

  always_comb begin
    half_tick = (div_ff == 24'(HALF_SEC_CYCLES - 1));
    nxt_div = half_tick ? 24'h000000 : div_ff + 24'h000001;
    nxt_phase = half_tick ? !phase_ff : phase_ff;
    sec_tick = half_tick && phase_ff;
  end

  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      div_ff <= 24'h000000;
      phase_ff <= 1'b0;
    end else begin
      div_ff <= nxt_div;
      phase_ff <= nxt_phase;
    end
  end

  // Failure persistence
  logic near_los_fail, far_los_fail, near_lof_fail, far_lof_fail;
  logic near_lpr_fail, far_lpr_fail;
  logic near_lof_crit, far_lof_crit;
  logic arm_ff;
  logic nxt_arm;

  xlm_persist #(.SET_TICKS(DECLARE_TICKS), .CLR_TICKS(CLEAR_TICKS))
      u_near_los (
    .core_clk_in(core_clk_in),
    .reset_in(reset_in),
    .tick_in(half_tick),
    .defect_in(defect_in.near_signal_absent),
    .block_in(1'b0),
    .force_set_in(defect_in.near_signal_absent && near_lof_crit),
    .force_clr_in(1'b0),
    .fail_out(near_los_fail),
    .criteria_out()
  );

  xlm_persist #(.SET_TICKS(DECLARE_TICKS), .CLR_TICKS(CLEAR_TICKS))
      u_far_los (
    .core_clk_in(core_clk_in),
    .reset_in(reset_in),
    .tick_in(half_tick),
    .defect_in(defect_in.far_signal_absent),
    .block_in(1'b0),
    .force_set_in(defect_in.far_signal_absent && far_lof_crit),
    .force_clr_in(1'b0),
    .fail_out(far_los_fail),
    .criteria_out()
  );

  // frame loss held off by signal loss
  xlm_persist #(.SET_TICKS(DECLARE_TICKS), .CLR_TICKS(CLEAR_TICKS))
      u_near_lof (
    .core_clk_in(core_clk_in),
    .reset_in(reset_in),
    .tick_in(half_tick),
    .defect_in(defect_in.severely_errored_frame),
    .block_in(defect_in.near_signal_absent || near_los_fail),
    .force_set_in(1'b0),
    .force_clr_in(near_los_fail),
    .fail_out(near_lof_fail),
    .criteria_out(near_lof_crit)
  );

  // far frame loss, cleared by far signal loss
  xlm_persist #(.SET_TICKS(DECLARE_TICKS), .CLR_TICKS(CLEAR_TICKS))
      u_far_lof (
    .core_clk_in(core_clk_in),
    .reset_in(reset_in),
    .tick_in(half_tick),
    .defect_in(defect_in.remote_defect_flag),
    .block_in(defect_in.far_signal_absent || far_los_fail),
    .force_set_in(1'b0),
    .force_clr_in(far_los_fail),
    .fail_out(far_lof_fail),
    .criteria_out(far_lof_crit)
  );

  xlm_persist #(.SET_TICKS(DECLARE_TICKS), .CLR_TICKS(CLEAR_TICKS))
      u_near_lpr (
    .core_clk_in(core_clk_in),
    .reset_in(reset_in),
    .tick_in(half_tick),
    .defect_in(defect_in.near_power_loss),
    .block_in(1'b0),
    .force_set_in(1'b0),
    .force_clr_in(1'b0),
    .fail_out(near_lpr_fail),
    .criteria_out()
  );

  // arm on far primitive; a break in signal loss disarms unless far power loss is declared
  always_comb begin
    nxt_arm = arm_ff;
    if (defect_in.far_power_loss) begin
      nxt_arm = 1'b1;
    end else if (!defect_in.near_signal_absent && !far_lpr_fail) begin
      nxt_arm = 1'b0;
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      arm_ff <= 1'b0;
    end else begin
      arm_ff <= nxt_arm;
    end
  end

  // far power loss timed on near signal loss
  xlm_persist #(.SET_TICKS(DECLARE_TICKS), .CLR_TICKS(CLEAR_TICKS))
      u_far_lpr (
    .core_clk_in(core_clk_in),
    .reset_in(reset_in),
    .tick_in(half_tick),
    .defect_in(defect_in.near_signal_absent),
    .block_in(!arm_ff),
    .force_set_in(1'b0),
    .force_clr_in(1'b0),
    .fail_out(far_lpr_fail),
    .criteria_out()
  );

  assign failure_out = '{far_power_loss: far_lpr_fail,
                         near_power_loss: near_lpr_fail,
                         far_frame_sync_lost: far_lof_fail,
                         near_frame_sync_lost: near_lof_fail,
                         far_signal_absent: far_los_fail,
                         near_signal_absent: near_los_fail};

  // Register control
  logic [31:0] ctrl_ff;
  logic [31:0] nxt_ctrl;
  logic clr_req;
  logic enable;

  always_comb begin
    nxt_ctrl = ctrl_ff;
    if (bus_in.wr && bus_in.addr == REG_CTRL) begin
      nxt_ctrl = {31'h00000000, bus_in.wdata[CTRL_ENABLE_BIT]};
    end
    clr_req = bus_in.wr && bus_in.addr == REG_CLEAR;
    enable = ctrl_ff[CTRL_ENABLE_BIT];
  end

  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      ctrl_ff <= CTRL_RESET;
    end else begin
      ctrl_ff <= nxt_ctrl;
    end
  end

  // Per-second accumulation
  logic [7:0] crc_sum_ff;
  logic [7:0] nxt_crc_sum;
  logic defect_seen_ff;
  logic nxt_defect_seen;
  logic [7:0] crc_now;
  logic defect_now;
  logic es_now;
  logic ses_now;

  always_comb begin
    crc_now = sat_add8(crc_sum_ff, crc_count(crc_anomaly_in));
    defect_now = defect_seen_ff || defect_in.near_signal_absent ||
                 defect_in.severely_errored_frame ||
                 defect_in.near_power_loss;
    es_now = (crc_now != 8'h00) || defect_now;
    ses_now = (crc_now >= SES_CRC_LIMIT) || defect_now;
    nxt_crc_sum = sec_tick ? 8'h00 : crc_now;
    nxt_defect_seen = sec_tick ? 1'b0 : defect_now;
  end

  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      crc_sum_ff <= 8'h00;
      defect_seen_ff <= 1'b0;
    end else begin
      crc_sum_ff <= nxt_crc_sum;
      defect_seen_ff <= nxt_defect_seen;
    end
  end

  // Second counters and availability
  logic [31:0] es_ff, ses_ff, uas_ff;
  logic [31:0] nxt_es, nxt_ses, nxt_uas;
  logic [3:0] run_ff;
  logic [3:0] nxt_run;
  xlm_avail_e avail_ff;
  xlm_avail_e nxt_avail;
  logic count_sec;

  always_comb begin
    nxt_es = es_ff;
    nxt_ses = ses_ff;
    nxt_uas = uas_ff;
    nxt_run = run_ff;
    nxt_avail = avail_ff;
    count_sec = sec_tick && enable;
    if (clr_req) begin
      nxt_es = 32'h00000000;
      nxt_ses = 32'h00000000;
      nxt_uas = 32'h00000000;
      nxt_run = 4'h0;
      nxt_avail = XLM_AVAILABLE;
    end else if (count_sec) begin
      if (es_now) begin
        nxt_es = es_ff + 32'h00000001;
      end
      if (ses_now) begin
        nxt_ses = ses_ff + 32'h00000001;
      end
      case (avail_ff)
        XLM_AVAILABLE: begin
          nxt_run = ses_now ? run_ff + 4'h1 : 4'h0;
          if (ses_now && run_ff == UAS_RUN - 4'h1) begin
            nxt_avail = XLM_UNAVAILABLE;
            nxt_run = 4'h0;
            nxt_uas = uas_ff + UAS_RUN_W;
          end
        end
        XLM_UNAVAILABLE: begin
          nxt_uas = uas_ff + 32'h00000001;
          nxt_run = ses_now ? 4'h0 : run_ff + 4'h1;
          if (!ses_now && run_ff == UAS_RUN - 4'h1) begin
            nxt_avail = XLM_AVAILABLE;
            nxt_run = 4'h0;
            nxt_uas = uas_ff + 32'h00000001 - UAS_RUN_W;
          end
        end
        default: begin
          nxt_avail = XLM_AVAILABLE;
          nxt_run = 4'h0;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      es_ff <= 32'h00000000;
      ses_ff <= 32'h00000000;
      uas_ff <= 32'h00000000;
      run_ff <= 4'h0;
      avail_ff <= XLM_AVAILABLE;
    end else begin
      es_ff <= nxt_es;
      ses_ff <= nxt_ses;
      uas_ff <= nxt_uas;
      run_ff <= nxt_run;
      avail_ff <= nxt_avail;
    end
  end

  assign unavailable_out = (avail_ff == XLM_UNAVAILABLE);
  assign sec_tick_out = sec_tick;

  // Register read, one cycle later; unmapped reads zero
  logic [31:0] rd_data_ff;
  logic [31:0] nxt_rd_data;

  always_comb begin
    nxt_rd_data = 32'h00000000;
    if (bus_in.rd) begin
      case (bus_in.addr)
        REG_CTRL: nxt_rd_data = ctrl_ff;
        REG_FAIL: nxt_rd_data = {26'h0000000, failure_out};
        REG_ES: nxt_rd_data = es_ff;
        REG_SES: nxt_rd_data = ses_ff;
        REG_UAS: nxt_rd_data = uas_ff;
        REG_STATE: nxt_rd_data = 32'(unavailable_out) << STATE_UNAVAIL_BIT;
        default: nxt_rd_data = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      rd_data_ff <= 32'h00000000;
    end else begin
      rd_data_ff <= nxt_rd_data;
    end
  end

  assign rd_data_out = rd_data_ff;

  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (reset_in);

  a_los_declare_cause: assert property (
    $rose(near_los_fail) |-> $past(defect_in.near_signal_absent))
    else $error("signal loss declared without defect");
  a_los_clear_cause: assert property (
    $fell(near_los_fail) |-> $past(!defect_in.near_signal_absent))
    else $error("signal loss cleared while defect present");
  a_lof_blocked_los: assert property (
    $rose(near_lof_fail) |->
    $past(!defect_in.near_signal_absent && !near_los_fail))
    else $error("frame loss declared during signal loss");
  a_lof_cleared_los: assert property (
    far_los_fail |=> !far_lof_fail)
    else $error("frame loss kept during signal loss failure");
  a_lpr_near_cause: assert property (
    $rose(near_lpr_fail) |-> $past(defect_in.near_power_loss))
    else $error("power loss declared without primitive");
  a_lpr_far_cause: assert property (
    $rose(far_lpr_fail) |->
    $past(defect_in.near_signal_absent && arm_ff))
    else $error("far power loss declared without sequence");
  a_fail_bit_map: assert property (
    failure_out.near_frame_sync_lost == near_lof_fail &&
    failure_out.far_power_loss == far_lpr_fail)
    else $error("failure field bit mismatch");
  a_es_counts: assert property (
    count_sec && !clr_req && crc_now != 8'h00 |=>
    es_ff == $past(es_ff) + 32'h00000001)
    else $error("errored second not counted");
  a_ses_counts: assert property (
    count_sec && !clr_req && crc_now >= 8'h12 |=>
    ses_ff == $past(ses_ff) + 32'h00000001)
    else $error("severe second not counted");
  a_uas_enter: assert property (
    count_sec && !clr_req && !unavailable_out && ses_now &&
    run_ff == 4'h9 |=> unavailable_out &&
    uas_ff == $past(uas_ff) + 32'h0000000A)
    else $error("unavailable entry not retroactive");
  a_uas_leave: assert property (
    count_sec && !clr_req && unavailable_out && !ses_now &&
    run_ff == 4'h9 |=> !unavailable_out &&
    uas_ff == $past(uas_ff) - 32'h00000009)
    else $error("unavailable exit not removed");
  a_sec_spacing: assert property (
    sec_tick |=> !sec_tick [*8])
    else $error("second ticks too close");

  c_los_declared: cover property ($rose(near_los_fail));
  c_unavailable: cover property ($rose(unavailable_out));
  c_far_lpr: cover property ($rose(far_lpr_fail));
  c_es_counted: cover property (count_sec && es_now);

endmodule // xlm_line_monitor
`default_nettype wire

//--- xlm_xcvr_model.sv
`default_nettype none
module xlm_xcvr_model
  import xlm_pkg::*;
(
  input wire logic core_clk_in,
  input wire logic reset_in,
  input wire xlm_pkg::xlm_defect_s hold_in,
  input wire logic far_pulse_in,
  input wire logic [7:0] burst_in,
  input wire logic load_in,
  output xlm_pkg::xlm_defect_s defect_out,
  output logic [xlm_pkg::CRC_GROUPS-1:0] crc_anomaly_out
);
  import xlm_pkg::*;

  xlm_defect_s nxt_defect;
  xlm_defect_s defect_ff;
  logic [7:0] nxt_pend;
  logic [7:0] pend_ff;
  logic [CRC_GROUPS-1:0] nxt_crc;
  logic [CRC_GROUPS-1:0] crc_ff;

  always_comb begin
    nxt_defect = hold_in;
    // Far power loss follows far_pulse_in, not the held level in hold_in
    nxt_defect.far_power_loss = far_pulse_in;
    nxt_pend = load_in ? burst_in : pend_ff;
    nxt_crc = '0;
    for (int g = 0; g < CRC_GROUPS; g++) begin
      if (nxt_pend != 8'h00) begin
        nxt_crc[g] = 1'b1;
        nxt_pend = nxt_pend - 8'h01;
      end
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      defect_ff <= '0;
      pend_ff <= 8'h00;
      crc_ff <= '0;
    end else begin
      defect_ff <= nxt_defect;
      pend_ff <= nxt_pend;
      crc_ff <= nxt_crc;
    end
  end

  assign defect_out = defect_ff;
  assign crc_anomaly_out = crc_ff;
endmodule // xlm_xcvr_model
`default_nettype wire

//--- xlm_line_monitor_test.sv
`default_nettype none
module xlm_line_monitor_test;
  import xlm_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;

  logic core_clk_in;
  logic reset_in;
  xlm_bus_s bus;
  xlm_defect_s hold;
  logic far_pulse;
  logic [7:0] burst;
  logic load;
  xlm_defect_s defect;
  logic [CRC_GROUPS-1:0] crc;
  logic [31:0] rd_data_out;
  xlm_fail_s failure_out;
  logic unavailable_out;
  logic sec_tick_out;
  int mismatches;
  int comparisons;
  int cyc;

  // Short half second keeps the 10 s clear run near 320 cycles
  xlm_line_monitor #(.HALF_SEC_CYCLES(16)) dut_u (
    .core_clk_in(core_clk_in),
    .reset_in(reset_in),
    .defect_in(defect),
    .crc_anomaly_in(crc),
    .bus_in(bus),
    .rd_data_out(rd_data_out),
    .failure_out(failure_out),
    .unavailable_out(unavailable_out),
    .sec_tick_out(sec_tick_out)
  );

  xlm_xcvr_model model_u (
    .core_clk_in(core_clk_in),
    .reset_in(reset_in),
    .hold_in(hold),
    .far_pulse_in(far_pulse),
    .burst_in(burst),
    .load_in(load),
    .defect_out(defect),
    .crc_anomaly_out(crc)
  );

  initial core_clk_in = 1'b0;
  always #25 core_clk_in = ~core_clk_in;

  task automatic stop_test();
    if (mismatches == 0 && comparisons > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  always @(posedge core_clk_in) begin
    cyc++;
    if (cyc == 10000) begin
      mismatches++;
      stop_test();
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    comparisons++;
    if (seen !== want) begin
      mismatches++;
      $display("unexpected at %0t: saw %h, wanted %h", $time, seen, want);
    end
  endtask

  task automatic cycles(input int n);
    repeat (n) @(posedge core_clk_in);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus <= '{a, d, 1'b1, 1'b0};
    @(posedge core_clk_in);
    bus.wr <= 1'b0;
    @(posedge core_clk_in);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] want);
    bus <= '{a, 32'h00000000, 1'b0, 1'b1};
    @(posedge core_clk_in);
    bus.rd <= 1'b0;
    @(negedge core_clk_in);
    check(rd_data_out, want);
    @(posedge core_clk_in);
  endtask

  task automatic fail_is(input logic [5:0] want);
    @(negedge core_clk_in);
    check({26'h0, failure_out}, {26'h0, want});
    @(posedge core_clk_in);
  endtask

  task automatic wait_bit(input int idx, input logic lvl, input int lim);
    int n;
    n = 0;
    @(negedge core_clk_in);
    while (failure_out[idx] !== lvl && n < lim) begin
      @(negedge core_clk_in);
      n++;
    end
    check(32'(failure_out[idx]), 32'(lvl));
    @(posedge core_clk_in);
  endtask

  // Returns just after the edge that closes the current second
  task automatic sec();
    int n;
    n = 0;
    @(negedge core_clk_in);
    while (sec_tick_out !== 1'b1 && n < 40) begin
      @(negedge core_clk_in);
      n++;
    end
    @(posedge core_clk_in);
  endtask

  task automatic load_burst(input logic [7:0] n);
    burst <= n;
    load <= 1'b1;
    @(posedge core_clk_in);
    load <= 1'b0;
  endtask

  task automatic persist(input xlm_defect_s d, input int idx);
    hold <= d;
    cycles(60);
    fail_is(6'h00); // not before two seconds
    wait_bit(idx, 1'b1, 30); // declared by 2.5 s
    fail_is(6'(1 << idx)); // only its own bit set
    hold <= '0;
    cycles(290);
    fail_is(6'(1 << idx)); // held through 9 s
    wait_bit(idx, 1'b0, 40); // cleared by 10 s
  endtask

  task automatic los_over_lof();
    hold <= xlm_defect_s'(6'h08);
    wait_bit(2, 1'b1, 100); // frame loss declared
    hold <= xlm_defect_s'(6'h28);
    wait_bit(0, 1'b1, 5); // declared at once
    fail_is(6'h01); // frame loss dropped
    cycles(100);
    fail_is(6'h01); // held off by signal loss
    hold <= '0;
    cycles(340);
    fail_is(6'h00); // both clear
  endtask

  task automatic far_power();
    hold <= xlm_defect_s'(6'h20);
    far_pulse <= 1'b1;
    @(posedge core_clk_in);
    far_pulse <= 1'b0;
    cycles(60);
    fail_is(6'h00); // not before two seconds
    wait_bit(5, 1'b1, 30); // far power loss declared
    cycles(2);
    fail_is(6'h21); // with near signal loss
    hold <= '0;
    cycles(290);
    fail_is(6'h21); // held through 9 s
    wait_bit(5, 1'b0, 40); // cleared by 10 s
  endtask

  task automatic counts();
    wr(REG_CLEAR, 32'h00000000);
    // Align so a burst never straddles a second boundary
    sec();
    load_burst(8'h11);
    sec();
    cycles(2);
    rd(REG_ES, 32'h1); // one errored second
    rd(REG_SES, 32'h0); // seventeen is not severe
    load_burst(8'h12);
    sec();
    cycles(2);
    rd(REG_ES, 32'h2); // second errored second
    rd(REG_SES, 32'h1); // eighteen is severe
    sec();
    cycles(2);
    rd(REG_ES, 32'h2); // clean second not counted
    wr(REG_CTRL, 32'h00000000);
    load_burst(8'h01);
    sec();
    cycles(2);
    rd(REG_ES, 32'h2); // counting frozen while disabled
    rd(REG_CTRL, 32'h0); // enable bit reads back
    wr(REG_CTRL, 32'h00000001);
  endtask

  task automatic unavail();
    wr(REG_CLEAR, 32'h00000000);
    sec();
    hold <= xlm_defect_s'(6'h02);
    repeat (9) sec();
    cycles(2);
    rd(REG_STATE, 32'h0); // nine severe seconds not enough
    // Drop inside the tenth second so it still counts as severe
    hold <= '0;
    sec();
    cycles(2);
    rd(REG_UAS, 32'hA); // ten seconds counted back
    rd(REG_STATE, 32'h1); // now unavailable
    check(32'(unavailable_out), 32'h1); // state on the port
    repeat (9) sec();
    cycles(2);
    rd(REG_UAS, 32'h13); // one per unavailable second
    sec();
    cycles(2);
    rd(REG_UAS, 32'hA); // clean run taken back
    rd(REG_SES, 32'hA); // defect makes severe seconds
    rd(REG_ES, 32'hA); // defect makes errored seconds
    check(32'(unavailable_out), 32'h0); // available again
  endtask

  initial begin
    mismatches = 0;
    comparisons = 0;
    cyc = 0;
    reset_in = 1'b1;
    bus = '0;
    hold = '0;
    far_pulse = 1'b0;
    burst = 8'h00;
    load = 1'b0;
    cycles(4);
    reset_in <= 1'b0;
    @(posedge core_clk_in);
    rd(REG_CTRL, 32'h1); // counting enabled out of reset
    @(negedge core_clk_in);
    check(rd_data_out, 32'h0); // read data stands one cycle only
    @(posedge core_clk_in);
    rd(REG_FAIL, 32'h0); // no failure out of reset
    rd(REG_UAS, 32'h0); // count starts at zero
    rd(8'h1C, 32'h0); // unmapped place reads zero
    wr(REG_FAIL, 32'h0000003F);
    rd(REG_FAIL, 32'h0); // failure field is read only
    for (int i = 0; i < 5; i++) begin
      persist(xlm_defect_s'(6'h20 >> i), i); // each failure but far power loss
    end
    los_over_lof();
    far_power();
    counts();
    unavail();
    stop_test();
  end
endmodule // xlm_line_monitor_test
`default_nettype wire
